// *** hw/reset_ctrl_pkg.sv ***
package reset_ctrl_pkg;

   // Register word addresses
   localparam logic [7:0] BYTE_TEST_ADDR    = 8'h64;
   localparam logic [7:0] HARDWARE_CONFIG_REG_ADDR       = 8'h74;
   localparam logic [7:0] POWER_MGMT_CONTROL_REG_ADDR     = 8'h84;
   localparam logic [7:0] EEPROM_COMMAND_REG_ADDR      = 8'hB0;
   localparam logic [7:0] PHY_BCR_ADDR      = 8'hC0;
   localparam logic [7:0] SCRATCH_ADDR      = 8'hC4;

   // Field positions
   localparam int SOFT_RESET_BIT  = 0;
   localparam int HARDWARE_CONFIG_REG_KEEP_LO  = 16;   // Bits 31:16 survive soft reset
   localparam int PMT_READY_BIT   = 0;
   localparam int PMT_MODE_LO     = 12;
   localparam int PMT_PHY_RST_BIT = 10;
   localparam int PHY_BCR_RST_BIT = 15;
   localparam int E2P_BUSY_BIT    = 31;

   // Reset values
   localparam logic [31:0] HARDWARE_CONFIG_REG_RESET  = 32'h0000_0000;
   localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
   localparam logic [15:0] PHY_BCR_RESET = 16'h3000;

   // Timing, at a 20 MHz clock
   localparam int CLK_MHZ       = 20;
   localparam int POR_TIME_MS   = 22;
   localparam int WAKE_TIME_US  = 1000;   // Well inside the 2 ms bound
   localparam int SOFT_RESET_BIT_TIME_US  = 2;
   localparam int PHYRST_TIME_US = 100;
   localparam int PHYBCR_TIME_US = 50;
   localparam int EEPROM_TIME_US = 20;
   localparam int POR_CYCLES    = POR_TIME_MS * 1000 * CLK_MHZ;
   localparam int WAKE_CYCLES   = WAKE_TIME_US * CLK_MHZ;
   localparam int SOFT_RESET_BIT_CYCLES   = SOFT_RESET_BIT_TIME_US * CLK_MHZ;
   localparam int PHYRST_CYCLES = PHYRST_TIME_US * CLK_MHZ;
   localparam int PHYBCR_CYCLES = PHYBCR_TIME_US * CLK_MHZ;
   localparam int EEPROM_CYCLES = EEPROM_TIME_US * CLK_MHZ;

   // Power states
   typedef enum logic [1:0] {
      PM_D0 = 2'b00,
      PM_D1 = 2'b01,
      PM_D2 = 2'b10
   } pm_state_t;

endpackage : reset_ctrl_pkg

// *** hw/reset_source_controller.sv ***
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/100ps
// Summary of operation
// - Five reset sources: power-on, pin, soft bit, PHY bit, PHY control bit.
// - Power-on holds the internal reset for about 22 ms.
// - Ready reads 0 until power-on reset and the core and PHY resets it starts have ended, then goes high.
// - Pin low resets the device; ready reads 0 until that reset ends.
// - Writing the byte test register wakes the device; ready within 2 ms.
// - Soft reset bit 0 self-clears after about 2 us.
// - Soft reset spares exempt bits and the host bus interface.
// - PHY reset bit 10 self-clears after about 100 us.
// - PHY control bit 15 self-clears when the PHY reset completes.
// - Power-on, pin and soft reset start an EEPROM presence check.
module reset_source_controller #(
   parameter int POR_CYCLES  = reset_ctrl_pkg::POR_CYCLES,
   parameter int WAKE_CYCLES = reset_ctrl_pkg::WAKE_CYCLES
) (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   // External reset pin
   input  wire logic        hw_reset_pin_n_in,
   // EEPROM presence
   input  wire logic        eeprom_present_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // Reset and status outputs to the rest of the chip
   output logic             core_reset_out,
   output logic             phy_reset_out,
   output logic             eeprom_loading_out,
   output logic             ready_out
);

   localparam int CW = 20;

   // Whole module state
   typedef struct packed {
      logic [CW-1:0]         por_cnt;
      logic                  por_done;
      logic [CW-1:0]         core_cnt;
      logic                  core_busy;
      logic [CW-1:0]         phy_cnt;
      logic                  phy_rst_bit;
      logic                  phy_bcr_rst;
      logic [CW-1:0]         ee_cnt;
      logic                  ee_busy;
      logic                  ee_found;
      logic [CW-1:0]         wake_cnt;
      logic                  waking;
      reset_ctrl_pkg::pm_state_t pm_mode;
      logic                  read_seen;
      logic [31:0]           hardware_config_reg;
      logic [15:0]           phy_bcr;
      logic [31:0]           scratch;
      logic [31:0]           rdata;
      logic                  pin_q;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic   ready;

   // Counter load value, truncated to the counter width
   function automatic logic [CW-1:0] load_cnt(input int cycles);
      load_cnt = CW'(cycles - 1);
   endfunction : load_cnt

   // All timers but the EEPROM check idle, no source asserted, mode D0
   assign ready = st_reg.por_done && !st_reg.core_busy && !st_reg.phy_rst_bit
                  && !st_reg.phy_bcr_rst && !st_reg.waking && st_reg.pin_q
                  && st_reg.pm_mode == reset_ctrl_pkg::PM_D0;

   // Next-state logic
   always_comb
   begin
      logic wr_ok;
      logic start_core;
      wr_ok      = 1'b0;
      start_core = 1'b0;
      st_next    = st_reg;
      st_next.pin_q = hw_reset_pin_n_in;
      st_next.rdata = 32'h0000_0000;

      // Power-on timer
      if (!st_reg.por_done)
      begin
         if (st_reg.por_cnt == '0)
         begin
            st_next.por_done = 1'b1;
            start_core       = 1'b1;
         end
         else
         begin
            st_next.por_cnt = st_reg.por_cnt - CW'(1);
         end
      end

      // Reset pin low: load register reset values, restart the sequence on release
      if (!st_reg.pin_q && st_reg.por_done)
      begin
         st_next.hardware_config_reg    = reset_ctrl_pkg::HARDWARE_CONFIG_REG_RESET;
         st_next.scratch   = reset_ctrl_pkg::SCRATCH_RESET;
         st_next.phy_bcr   = reset_ctrl_pkg::PHY_BCR_RESET;
         st_next.pm_mode   = reset_ctrl_pkg::PM_D0;
         st_next.read_seen = 1'b0;
         st_next.waking    = 1'b0;
      end
      if (st_reg.pin_q == 1'b0 && hw_reset_pin_n_in && st_reg.por_done)
      begin
         start_core = 1'b1;
      end

      // Soft reset countdown
      if (st_reg.core_busy)
      begin
         if (st_reg.core_cnt == '0)
         begin
            st_next.core_busy = 1'b0;
            st_next.hardware_config_reg[reset_ctrl_pkg::SOFT_RESET_BIT] = 1'b0;
         end
         else
         begin
            st_next.core_cnt = st_reg.core_cnt - CW'(1);
         end
      end

      // EEPROM presence check
      if (st_reg.ee_busy)
      begin
         if (st_reg.ee_cnt == '0)
         begin
            st_next.ee_busy  = 1'b0;
            st_next.ee_found = eeprom_present_in;
         end
         else
         begin
            st_next.ee_cnt = st_reg.ee_cnt - CW'(1);
         end
      end

      // PHY reset countdown, shared by both PHY sources
      if (st_reg.phy_rst_bit || st_reg.phy_bcr_rst)
      begin
         if (st_reg.phy_cnt == '0)
         begin
            st_next.phy_rst_bit = 1'b0;
            st_next.phy_bcr_rst = 1'b0;
            st_next.phy_bcr[reset_ctrl_pkg::PHY_BCR_RST_BIT] = 1'b0;
         end
         else
         begin
            st_next.phy_cnt = st_reg.phy_cnt - CW'(1);
         end
      end

      // Wake timer
      if (st_reg.waking)
      begin
         if (st_reg.wake_cnt == '0)
         begin
            st_next.waking = 1'b0;
         end
         else
         begin
            st_next.wake_cnt = st_reg.wake_cnt - CW'(1);
         end
      end

      // Reads unlock writes
      if (rd_in && st_reg.por_done && st_reg.pin_q)
      begin
         st_next.read_seen = 1'b1;
         case (addr_in)
            reset_ctrl_pkg::BYTE_TEST_ADDR: st_next.rdata = 32'h8765_4321;
            reset_ctrl_pkg::HARDWARE_CONFIG_REG_ADDR:    st_next.rdata = st_reg.hardware_config_reg;
            reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR:
            begin
               st_next.rdata[reset_ctrl_pkg::PMT_READY_BIT]   = ready;
               st_next.rdata[reset_ctrl_pkg::PMT_PHY_RST_BIT] = st_reg.phy_rst_bit;
               st_next.rdata[reset_ctrl_pkg::PMT_MODE_LO +: 2] = st_reg.pm_mode;
            end
            reset_ctrl_pkg::EEPROM_COMMAND_REG_ADDR:
            begin
               st_next.rdata[reset_ctrl_pkg::E2P_BUSY_BIT] = st_reg.ee_busy;
               st_next.rdata[0] = st_reg.ee_found;
            end
            reset_ctrl_pkg::PHY_BCR_ADDR:   st_next.rdata = {16'h0000, st_reg.phy_bcr};
            reset_ctrl_pkg::SCRATCH_ADDR:   st_next.rdata = st_reg.scratch;
            default:                        st_next.rdata = 32'h0000_0000;
         endcase
      end

      // Writes, only once a read has been seen
      wr_ok = wr_in && st_reg.read_seen && st_reg.pin_q && st_reg.por_done;
      if (wr_ok && st_reg.pm_mode != reset_ctrl_pkg::PM_D0)
      begin
         if (addr_in == reset_ctrl_pkg::BYTE_TEST_ADDR)
         begin
            st_next.pm_mode  = reset_ctrl_pkg::PM_D0;
            st_next.waking   = 1'b1;
            st_next.wake_cnt = load_cnt(WAKE_CYCLES);
            st_next.read_seen = 1'b0;
         end
      end
      else if (wr_ok && !st_reg.core_busy && !st_reg.waking)
      begin
         case (addr_in)
            reset_ctrl_pkg::HARDWARE_CONFIG_REG_ADDR:
            begin
               st_next.hardware_config_reg = wdata_in;
               if (wdata_in[reset_ctrl_pkg::SOFT_RESET_BIT])
               begin
                  start_core = 1'b1;
               end
            end
            reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR:
            begin
               if (wdata_in[reset_ctrl_pkg::PMT_PHY_RST_BIT])
               begin
                  st_next.phy_rst_bit = 1'b1;
                  st_next.phy_cnt     = load_cnt(reset_ctrl_pkg::PHYRST_CYCLES);
               end
               if (wdata_in[reset_ctrl_pkg::PMT_MODE_LO +: 2] == 2'b01 ||
                   wdata_in[reset_ctrl_pkg::PMT_MODE_LO +: 2] == 2'b10)
               begin
                  st_next.pm_mode = reset_ctrl_pkg::pm_state_t'(
                     wdata_in[reset_ctrl_pkg::PMT_MODE_LO +: 2]);
               end
            end
            reset_ctrl_pkg::PHY_BCR_ADDR:
            begin
               st_next.phy_bcr = wdata_in[15:0];
               if (wdata_in[reset_ctrl_pkg::PHY_BCR_RST_BIT] && !st_reg.phy_rst_bit)
               begin
                  st_next.phy_bcr_rst = 1'b1;
                  st_next.phy_cnt     = load_cnt(reset_ctrl_pkg::PHYBCR_CYCLES);
               end
            end
            reset_ctrl_pkg::SCRATCH_ADDR:   st_next.scratch = wdata_in;
            default:                        st_next.scratch = st_reg.scratch;
         endcase
      end

      // Soft, pin or power-on completion starts a core reset pulse
      if (start_core)
      begin
         st_next.core_busy = 1'b1;
         st_next.core_cnt  = load_cnt(reset_ctrl_pkg::SOFT_RESET_BIT_CYCLES);
         st_next.ee_busy   = 1'b1;
         st_next.ee_cnt    = load_cnt(reset_ctrl_pkg::EEPROM_CYCLES);
         // Exempt fields and bus logic keep their value
         st_next.hardware_config_reg[reset_ctrl_pkg::HARDWARE_CONFIG_REG_KEEP_LO-1:1] = '0;
         st_next.phy_rst_bit = 1'b1;
         st_next.phy_cnt     = load_cnt(reset_ctrl_pkg::PHYRST_CYCLES);
      end
   end

   // State register
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st_reg          <= '0;
         st_reg.por_cnt  <= load_cnt(POR_CYCLES);
         st_reg.phy_bcr  <= reset_ctrl_pkg::PHY_BCR_RESET;
         st_reg.hardware_config_reg   <= reset_ctrl_pkg::HARDWARE_CONFIG_REG_RESET;
         st_reg.scratch  <= reset_ctrl_pkg::SCRATCH_RESET;
         st_reg.pm_mode  <= reset_ctrl_pkg::PM_D0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign rdata_out          = st_reg.rdata;
   assign core_reset_out     = !st_reg.por_done || !st_reg.pin_q || st_reg.core_busy;
   assign phy_reset_out      = st_reg.phy_rst_bit || st_reg.phy_bcr_rst || !st_reg.por_done;
   assign eeprom_loading_out = st_reg.ee_busy;
   assign ready_out          = ready;

   // Ready only after power-on, core and PHY bit resets have gone quiet
   a_ready_quiet: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      ready_out |-> (st_reg.por_done && !st_reg.core_busy && !st_reg.phy_rst_bit))
      else $error("ready high while a reset is active");

   // Soft reset bit clears within its timer
   sequence soft_reset_bit_start;
      wr_in && addr_in == reset_ctrl_pkg::HARDWARE_CONFIG_REG_ADDR && wdata_in[0] && st_reg.read_seen
      && st_reg.pin_q && st_reg.por_done && st_reg.pm_mode == reset_ctrl_pkg::PM_D0
      && !st_reg.core_busy && !st_reg.waking;
   endsequence
   a_soft_reset_bit_clears: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      soft_reset_bit_start |=> st_reg.hardware_config_reg[0] ##[1:45] !st_reg.hardware_config_reg[0])
      else $error("soft reset bit did not self-clear");

   a_soft_reset_bit_eeprom: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      soft_reset_bit_start |=> st_reg.ee_busy)
      else $error("eeprom check not started by soft reset");

   a_pin_ready: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !st_reg.pin_q |-> !ready_out)
      else $error("ready high during pin reset");

   a_por_ready: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !st_reg.por_done |-> (!ready_out && core_reset_out))
      else $error("ready high before power-on reset ends");

   // Checker helpers: cycles spent with the PHY reset bit set and in the wake timer
   logic [CW-1:0] phy_hold_reg;
   logic [CW-1:0] wake_hold_reg;
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         phy_hold_reg  <= '0;
         wake_hold_reg <= '0;
      end
      else
      begin
         phy_hold_reg  <= st_reg.phy_rst_bit ? phy_hold_reg + CW'(1) : '0;
         wake_hold_reg <= st_reg.waking ? wake_hold_reg + CW'(1) : '0;
      end
   end

   a_phy_rst_time: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      $rose(st_reg.phy_rst_bit) |-> st_reg.phy_rst_bit [*8])
      else $error("PHY reset bit timing wrong");

   a_phy_rst_bound: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      phy_hold_reg <= CW'(reset_ctrl_pkg::PHYRST_CYCLES))
      else $error("PHY reset bit held too long");

   a_bcr_clears: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      $fell(st_reg.phy_bcr_rst) |-> !st_reg.phy_bcr[15])
      else $error("PHY control reset bit stuck");

   a_wake_bound: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      wake_hold_reg <= CW'(WAKE_CYCLES))
      else $error("wake timer runs too long");

   a_soft_keep: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (soft_reset_bit_start) |=> st_reg.hardware_config_reg[31:16] == $past(wdata_in[31:16]))
      else $error("exempt bits lost on soft reset");

endmodule : reset_source_controller

// *** verification/host_model.sv ***
`timescale 1ns/100ps
// Host processor on the register port
module host_model #(
   parameter int POLL_LIMIT = 4000
) (
   // Clock
   input  wire logic        ref_clk_in,
   // Register port
   input  wire logic [31:0] rdata_in,
   output logic      [7:0]  addr_out,
   output logic      [31:0] wdata_out,
   output logic             wr_out,
   output logic             rd_out
);
   // Idle bus at time zero
   initial
   begin
      addr_out  = 8'h00;
      wdata_out = 32'h0000_0000;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end

   // One-cycle write strobe, data scrambled once released
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge ref_clk_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
   endtask : bus_write

   // One-cycle read strobe, data taken in the next cycle
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge ref_clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask : bus_read

   // Poll a status bit with reads only, give up after the limit
   task automatic poll_bit(input logic [7:0] a, input int b, input logic lvl,
                           output logic ok);
      logic [31:0] d;
      int          n;
      ok = 1'b0;
      for (n = 0; n < POLL_LIMIT && !ok; n++)
      begin
         bus_read(a, d);
         ok = (d[b] === lvl);
      end
   endtask : poll_bit
endmodule : host_model

// *** verification/test_reset_source_controller.sv ***
`timescale 1ns/100ps
// Self-checking bench for the reset source controller
module test_reset_source_controller;
   localparam int POR_CYC  = 100;
   localparam int WAKE_CYC = 50;

   logic        clk        = 1'b0;
   logic        arst_n     = 1'b0;
   logic        pin_n      = 1'b1;
   logic        ee_present = 1'b0;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        core_rst;
   logic        phy_rst;
   logic        ee_busy;
   logic        ready;
   logic [3:0]  flags;
   int          miscompares = 0;
   int          comparisons = 0;
   int          seed        = 32'h50d9e265;
   logic [31:0] d;
   logic [31:0] rnd;
   logic        ok;
   int          n;

   // Clock, 50 ns period
   always #25 clk = ~clk;
   assign flags = {ee_busy, phy_rst, core_rst, ready};

   reset_source_controller #(.POR_CYCLES(POR_CYC), .WAKE_CYCLES(WAKE_CYC)) u_dut (
      .ref_clk_in        (clk),
      .arst_n_in         (arst_n),
      .hw_reset_pin_n_in (pin_n),
      .eeprom_present_in (ee_present),
      .addr_in           (addr),
      .wdata_in          (wdata),
      .wr_in             (wr),
      .rd_in             (rd),
      .rdata_out         (rdata),
      .core_reset_out    (core_rst),
      .phy_reset_out     (phy_rst),
      .eeprom_loading_out(ee_busy),
      .ready_out         (ready)
   );

   host_model u_host (
      .ref_clk_in(clk),
      .rdata_in  (rdata),
      .addr_out  (addr),
      .wdata_out (wdata),
      .wr_out    (wr),
      .rd_out    (rd)
   );

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // Count edges until a flag reaches a level
   task automatic wait_flag(input int idx, input logic lvl, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clk);
         cnt++;
      end
      while (flags[idx] !== lvl && cnt < 5000);
   endtask : wait_flag

   // One when a measured span is within three cycles of the target
   function automatic logic [31:0] near(input int got, input int exp);
      return {31'h0, (got >= exp - 3 && got <= exp + 3)};
   endfunction : near

   // Ready never shows while core or PHY is held in reset
   always @(negedge clk)
      if (arst_n && (core_rst || phy_rst) && ready !== 1'b0)
         check({31'h0, ready}, 32'h0);

   // Main sequence
   initial
   begin
      rnd = $random(seed);
      ee_present = rnd[0];
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (POR_CYC - 10) @(posedge clk);
      check({30'h0, core_rst, ready}, 32'h2);
      u_host.poll_bit(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, 0, 1'b1, ok);
      check({31'h0, ok}, 32'h1);
      u_host.poll_bit(reset_ctrl_pkg::EEPROM_COMMAND_REG_ADDR, 31, 1'b0, ok);
      u_host.bus_read(reset_ctrl_pkg::EEPROM_COMMAND_REG_ADDR, d);
      check({30'h0, ok, d[0]}, {30'h0, 1'b1, ee_present});
      // Soft reset keeps the exempt upper half
      rnd = $random(seed);
      u_host.bus_write(reset_ctrl_pkg::HARDWARE_CONFIG_REG_ADDR, {rnd[31:16], 16'h0001});
      wait_flag(1, 1'b0, n);
      check(near(n, reset_ctrl_pkg::SOFT_RESET_BIT_CYCLES), 32'h1);
      check({31'h0, ee_busy}, 32'h1);
      u_host.bus_read(reset_ctrl_pkg::HARDWARE_CONFIG_REG_ADDR, d);
      check(d, {rnd[31:16], 16'h0000});
      u_host.poll_bit(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, 0, 1'b1, ok);
      // PHY reset from the power control bit
      u_host.bus_write(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, 32'h0000_0400);
      wait_flag(2, 1'b0, n);
      check(near(n, reset_ctrl_pkg::PHYRST_CYCLES), 32'h1);
      u_host.poll_bit(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, 0, 1'b1, ok);
      u_host.bus_read(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, d);
      check(d & 32'h0000_0401, 32'h0000_0001);
      // PHY reset from the PHY control bit
      u_host.bus_write(reset_ctrl_pkg::PHY_BCR_ADDR, 32'h0000_B000);
      wait_flag(2, 1'b0, n);
      check(near(n, reset_ctrl_pkg::PHYBCR_CYCLES), 32'h1);
      u_host.bus_read(reset_ctrl_pkg::PHY_BCR_ADDR, d);
      check({16'h0, d[15:0]}, {16'h0, reset_ctrl_pkg::PHY_BCR_RESET});
      u_host.bus_write(reset_ctrl_pkg::SCRATCH_ADDR, rnd);
      // Sleep in each low-power mode, then wake by the byte test write
      for (int m = 1; m <= 2; m++)
      begin
         u_host.bus_write(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, 32'(m << 12));
         @(posedge clk);
         @(posedge clk);
         check({31'h0, ready}, 32'h0);
         u_host.bus_write(reset_ctrl_pkg::SCRATCH_ADDR, ~rnd);
         u_host.bus_write(reset_ctrl_pkg::BYTE_TEST_ADDR, $random(seed));
         wait_flag(0, 1'b1, n);
         check(near(n, WAKE_CYC), 32'h1);
         u_host.bus_read(reset_ctrl_pkg::SCRATCH_ADDR, d);
         check(d, rnd);
      end
      // Pin reset, then a write with no read before it
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (5) @(posedge clk);
      check({30'h0, core_rst, ready}, 32'h2);
      pin_n <= 1'b1;
      wait_flag(1, 1'b0, n);
      u_host.bus_write(reset_ctrl_pkg::SCRATCH_ADDR, ~rnd);
      u_host.poll_bit(reset_ctrl_pkg::POWER_MGMT_CONTROL_REG_ADDR, 0, 1'b1, ok);
      check({31'h0, ok}, 32'h1);
      u_host.bus_read(reset_ctrl_pkg::SCRATCH_ADDR, d);
      check(d, reset_ctrl_pkg::SCRATCH_RESET);
      u_host.bus_read(reset_ctrl_pkg::HARDWARE_CONFIG_REG_ADDR, d);
      check(d, reset_ctrl_pkg::HARDWARE_CONFIG_REG_RESET);
      u_host.poll_bit(reset_ctrl_pkg::EEPROM_COMMAND_REG_ADDR, 31, 1'b0, ok);
      check({31'h0, ok}, 32'h1);
      tally_and_finish();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
endmodule : test_reset_source_controller
